// >>> verilog/bsr_defs.vh
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH
// ==========================================
// cache configuration codes
`define BSR_CFG_OFF   3'h0
`define BSR_CFG_FOUR1 3'h1
`define BSR_CFG_TWO2  3'h2
`define BSR_CFG_NONE3 3'h3
`define BSR_CFG_FOUR4 3'h4
`define BSR_CFG_TWO5  3'h5
// ==========================================
// switch kinds
`define BSR_SW_FAIL   2'h1
`define BSR_SW_DETACH 2'h2
`define BSR_SW_ATTACH 2'h3
// ==========================================
// widths and reset values
`define BSR_CID_W     8
`define BSR_ERR_W     8
`define BSR_LINES8    1'b1
`define BSR_LINES_RST 1'b0
`define BSR_CFG_RST   3'h0
`define BSR_ERR_NONE  8'h00
`define BSR_SYNC_RST  2'h0
`endif

// >>> verilog/bsr_recovery.v
// Behaviour
// - any switch of the unit's own bus pair invalidates whole cache directory and forces eight-line layout
// - cache stays enabled after a switch; later requests refill it
// - units on the unaffected bus pair keep directory and configuration
// - failure/detach steps configuration down; attach steps it back up
// - a switch clears the prefetch enable bit on both units of the pair
// - with prefetch off, data requests are served from backplane memory
// - prefetch start while enable is zero is ignored
// - unit on the failed bus drops outstanding prefetch reads
// - pair split happens only in warm reset, never on error report
// - split enabled after cold reset; software may set split disable
// - split needs warm reset, disable clear, own permanent error set
// - own permanent error set on confinement match with pair not joined
// - a split sets separated bit and picks the active half
// - master active on first split, roles swap on each later split
// - separated 1, toggle 0, active/silent per master and reset parity
// - silent unit drives no backplane bus or error report lines
// - silent unit still answers interagent requests
// - same transient error twice before window end counts as permanent
// - cold reset clears split control bits, warm reset keeps them
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defs.vh"

module bsr_recovery (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       cold_reset,
  input  wire       is_master,
  input  wire       on_affected_pair,
  input  wire       on_failed_bus,
  input  wire       bus_switch,
  input  wire [1:0] switch_kind,
  input  wire [2:0] cache_cfg_wr_data,
  input  wire       cache_cfg_wr,
  input  wire       cache_enable_wr_data,
  input  wire       cache_enable_wr,
  input  wire       prefetch_enable_set,
  input  wire       prefetch_enable_clear,
  input  wire       prefetch_start,
  input  wire       prefetch_read_req,
  input  wire       prefetch_read_done,
  input  wire       data_req,
  input  wire       split_disable_wr_data,
  input  wire       split_disable_wr,
  input  wire       err_report,
  input  wire       err_transient,
  input  wire [7:0] err_confinement_identifier,
  input  wire [7:0] err_code,
  input  wire [7:0] register_a,
  input  wire       shadow_pair_joined,
  input  wire       end_error_window,
  input  wire       interagent_request_hit,
  input  wire       bus_drive_req,
  input  wire       bus_error_report_req,
  output reg        cache_invalidate_all,
  output reg        line_layout_eight,
  output reg  [2:0] cache_cfg,
  output reg        cache_enabled,
  output reg        prefetch_enable,
  output reg        prefetch_active,
  output reg        prefetch_outstanding,
  output reg        data_from_memory,
  output reg        own_permanent_error_bit,
  output reg        split_disable_bit,
  output reg        separated_pair,
  output reg        toggle_bit,
  output reg        active_component,
  output reg        silent,
  output reg        permanent_error,
  output wire       backplane_bus_oe,
  output wire       bus_error_report_lines_oe,
  output wire       interagent_request_ack
);

  // ==========================================
  // configuration stepping
  function [2:0] bsr_step_down;
    input [2:0] cfg;
    begin
      case (cfg)
        `BSR_CFG_FOUR1: bsr_step_down = `BSR_CFG_TWO2;
        `BSR_CFG_FOUR4: bsr_step_down = `BSR_CFG_TWO5;
        `BSR_CFG_TWO2:  bsr_step_down = `BSR_CFG_NONE3;
        `BSR_CFG_TWO5:  bsr_step_down = `BSR_CFG_NONE3;
        default:        bsr_step_down = `BSR_CFG_OFF;
      endcase
    end
  endfunction

  // reverse of the step; the pre-failure flavour is remembered
  function [2:0] bsr_step_up;
    input [2:0] cfg;
    input [2:0] orig;
    begin
      case (cfg)
        `BSR_CFG_OFF:   bsr_step_up = `BSR_CFG_NONE3;
        `BSR_CFG_NONE3: begin
          if (orig == `BSR_CFG_TWO5 || orig == `BSR_CFG_FOUR4) begin
            bsr_step_up = `BSR_CFG_TWO5;
          end else begin
            bsr_step_up = `BSR_CFG_TWO2;
          end
        end
        `BSR_CFG_TWO2:  bsr_step_up = `BSR_CFG_FOUR1;
        `BSR_CFG_TWO5:  bsr_step_up = `BSR_CFG_FOUR4;
        default:        bsr_step_up = cfg;
      endcase
    end
  endfunction

  // ==========================================
  // switch decode
  wire       switch_here = bus_switch & on_affected_pair;
  wire       step_down   = switch_kind != `BSR_SW_ATTACH;
  reg  [2:0] orig_cfg;

  // ==========================================
  // cache reconfiguration
  reg  [2:0] next_cache_cfg;
  reg  [2:0] next_orig_cfg;
  reg        next_line_layout_eight;

  always @* begin
    next_cache_cfg         = cache_cfg;
    next_orig_cfg          = orig_cfg;
    next_line_layout_eight = line_layout_eight;
    if (switch_here) begin
      next_line_layout_eight = `BSR_LINES8;
      if (step_down) begin
        next_cache_cfg = bsr_step_down(cache_cfg);
      end else begin
        next_cache_cfg = bsr_step_up(cache_cfg, orig_cfg);
      end
    end else if (cache_cfg_wr) begin
      next_cache_cfg         = cache_cfg_wr_data;
      next_orig_cfg          = cache_cfg_wr_data;
      next_line_layout_eight = `BSR_LINES_RST;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_layout_eight <= `BSR_LINES_RST;
      cache_cfg         <= `BSR_CFG_RST;
      orig_cfg          <= `BSR_CFG_RST;
    end else begin
      line_layout_eight <= next_line_layout_eight;
      cache_cfg         <= next_cache_cfg;
      orig_cfg          <= next_orig_cfg;
    end
  end

  // one-cycle strobe to the directory
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cache_invalidate_all <= 1'b0;
    end else begin
      cache_invalidate_all <= switch_here;
    end
  end

  // enable untouched by a switch so refills use the new layout
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cache_enabled <= 1'b0;
    end else if (cache_enable_wr) begin
      cache_enabled <= cache_enable_wr_data;
    end
  end

  // ==========================================
  // prefetch channel control
  // switch beats a same-cycle software set
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_enable <= 1'b0;
    end else if (switch_here) begin
      prefetch_enable <= 1'b0;
    end else if (prefetch_enable_set) begin
      prefetch_enable <= 1'b1;
    end else if (prefetch_enable_clear) begin
      prefetch_enable <= 1'b0;
    end
  end

  // a start with enable low leaves the channel idle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_active <= 1'b0;
    end else if (switch_here || !prefetch_enable) begin
      prefetch_active <= 1'b0;
    end else if (prefetch_start) begin
      prefetch_active <= 1'b1;
    end
  end

  // reads in flight on a dead bus are simply forgotten
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prefetch_outstanding <= 1'b0;
    end else if (switch_here && on_failed_bus) begin
      prefetch_outstanding <= 1'b0;
    end else if (prefetch_read_req && prefetch_active) begin
      prefetch_outstanding <= 1'b1;
    end else if (prefetch_read_done) begin
      prefetch_outstanding <= 1'b0;
    end
  end

  // slower path: buffer contents may not match the new interleave
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_from_memory <= 1'b0;
    end else begin
      data_from_memory <= data_req & ~(prefetch_enable & prefetch_active);
    end
  end

  // ==========================================
  // error classification
  reg       window_open;
  reg [7:0] last_err;
  wire      repeat_err = err_report & err_transient & window_open &
                         (err_code == last_err);
  wire      own_match  = err_report & (err_confinement_identifier == register_a) &
                         ~shadow_pair_joined;

  // a new transient report wins over the same-cycle window end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      window_open <= 1'b0;
      last_err    <= `BSR_ERR_NONE;
    end else if (err_report && err_transient) begin
      window_open <= 1'b1;
      last_err    <= err_code;
    end else if (end_error_window) begin
      window_open <= 1'b0;
    end
  end

  // only the code is compared; a different code restarts the window
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      permanent_error <= 1'b0;
    end else begin
      permanent_error <= (err_report & ~err_transient) | repeat_err;
    end
  end

  // ==========================================
  // split control; survives warm reset, so no async clear here
  reg       in_reset;
  reg       reset_cold;
  reg       split_seen;
  reg [1:0] rst_sync;
  reg       next_own_permanent_error_bit;
  reg       next_split_disable_bit;
  reg       next_separated_pair;
  reg       next_toggle_bit;
  reg       next_active_component;
  reg       next_silent;
  reg       next_split_seen;
  wire      release_edge = in_reset & rst_sync[1];
  wire      running      = rst_sync[1] & ~in_reset;
  wire      split_now    = release_edge & ~reset_cold & ~split_disable_bit &
                           own_permanent_error_bit;

  // split decided once, on the third edge after release, never on a report
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= `BSR_SYNC_RST;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // cold/warm flag kept from the last edge seen with rst_sync[1] low, which is the second edge after release
  always @(posedge clk) begin
    if (!rst_sync[1]) begin
      in_reset   <= 1'b1;
      reset_cold <= cold_reset;
    end else begin
      in_reset   <= 1'b0;
    end
  end

  // all split bits move only here
  always @* begin
    next_own_permanent_error_bit = own_permanent_error_bit;
    next_split_disable_bit       = split_disable_bit;
    next_separated_pair          = separated_pair;
    next_toggle_bit              = toggle_bit;
    next_active_component        = active_component;
    next_silent                  = silent;
    next_split_seen              = split_seen;
    if (release_edge && reset_cold) begin
      next_own_permanent_error_bit = 1'b0;
      next_split_disable_bit       = 1'b0;
      next_separated_pair          = 1'b0;
      next_toggle_bit              = 1'b0;
      next_active_component        = 1'b0;
      next_silent                  = 1'b0;
      next_split_seen              = 1'b0;
    end else if (split_now) begin
      next_separated_pair   = 1'b1;
      next_toggle_bit       = 1'b0;
      next_split_seen       = 1'b1;
      // first split: master active; then alternate
      next_active_component = split_seen ? ~active_component : is_master;
      next_silent           = split_seen ? active_component : ~is_master;
    end else if (running) begin
      if (own_match) begin
        next_own_permanent_error_bit = 1'b1;
      end
      if (split_disable_wr) begin
        next_split_disable_bit = split_disable_wr_data;
      end
    end
  end

  // no reset: these bits must outlive a warm reset
  always @(posedge clk) begin
    own_permanent_error_bit <= next_own_permanent_error_bit;
    split_disable_bit       <= next_split_disable_bit;
    separated_pair          <= next_separated_pair;
    toggle_bit              <= next_toggle_bit;
    active_component        <= next_active_component;
    silent                  <= next_silent;
    split_seen              <= next_split_seen;
  end

  // ==========================================
  // pin gating
  // silent half is cut off the bus and the report lines
  assign backplane_bus_oe          = bus_drive_req & ~silent;
  assign bus_error_report_lines_oe = bus_error_report_req & ~silent;
  // interagent path is left open so software can rejoin the pair
  assign interagent_request_ack    = interagent_request_hit;

endmodule
`default_nettype wire

// >>> dv/bsr_reset_src.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// reset logic model: cold/warm flag held steady across the pulse
module bsr_reset_src (
  input  wire logic clk,
  input  wire logic do_reset,
  input  wire logic want_cold,
  output var  logic reset_n = 1'b0,
  output var  logic cold_reset = 1'b1
);
  logic [1:0] cnt = 2'h2;
  logic       req_q = 1'b0;
  // request caught on rising edge so the falling-edge logic never races the bench
  always @(posedge clk) req_q <= do_reset;
  always @(negedge clk) begin
    if (req_q) begin
      reset_n <= 1'b0;
      cold_reset <= want_cold;
      cnt <= 2'h2;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      reset_n <= (cnt == 2'h1);
    end
  end
endmodule
`default_nettype wire

// >>> dv/bsr_recovery_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// checker
module bsr_recovery_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       bus_switch,
  input wire logic       on_affected_pair,
  input wire logic       on_failed_bus,
  input wire logic [1:0] switch_kind,
  input wire logic [2:0] cache_cfg,
  input wire logic       cache_cfg_wr,
  input wire logic       cache_enable_wr,
  input wire logic       cache_enabled,
  input wire logic       cache_invalidate_all,
  input wire logic       line_layout_eight,
  input wire logic       prefetch_start,
  input wire logic       prefetch_enable,
  input wire logic       prefetch_active,
  input wire logic       prefetch_outstanding,
  input wire logic       err_report,
  input wire logic       shadow_pair_joined,
  input wire logic [7:0] err_confinement_identifier,
  input wire logic [7:0] register_a,
  input wire logic       own_permanent_error_bit,
  input wire logic       separated_pair,
  input wire logic       toggle_bit,
  input wire logic       active_component,
  input wire logic       silent,
  input wire logic       backplane_bus_oe,
  input wire logic       bus_error_report_lines_oe,
  input wire logic       interagent_request_hit,
  input wire logic       interagent_request_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_switch_invalidates: assert property (bus_switch && on_affected_pair
    |=> cache_invalidate_all && line_layout_eight) else $error("switch without invalidate");
  a_cache_stays: assert property (bus_switch && on_affected_pair && cache_enabled
    && !cache_enable_wr |=> cache_enabled) else $error("cache dropped on switch");
  a_other_pair_keeps: assert property (bus_switch && !on_affected_pair && !cache_cfg_wr
    |=> $stable(cache_cfg) && !cache_invalidate_all) else $error("other pair touched");
  a_step_to_off: assert property (bus_switch && on_affected_pair && switch_kind != 2'h3
    && cache_cfg == 3'h3 |=> cache_cfg == 3'h0) else $error("no step to off");
  a_prefetch_off: assert property (bus_switch && on_affected_pair
    |=> !prefetch_enable) else $error("prefetch left on");
  a_start_ignored: assert property (prefetch_start && !prefetch_enable
    |=> !$rose(prefetch_active)) else $error("start while disabled");
  a_reads_dropped: assert property (bus_switch && on_affected_pair && on_failed_bus
    |=> !prefetch_outstanding) else $error("prefetch read kept");
  a_own_error_set: assert property (err_report && err_confinement_identifier == register_a
    && !shadow_pair_joined |=> own_permanent_error_bit) else $error("own error not set");
  a_halves_differ: assert property (separated_pair
    |-> active_component != silent && !toggle_bit) else $error("bad split bits");
  a_silent_quiet: assert property (silent
    |-> !backplane_bus_oe && !bus_error_report_lines_oe) else $error("silent unit drives");
  a_silent_answers: assert property (silent && interagent_request_hit
    |-> interagent_request_ack) else $error("silent unit deaf");
  c_switch: cover property (bus_switch && on_affected_pair);
  c_split: cover property ($rose(separated_pair));
  c_silent_req: cover property (silent && interagent_request_hit);
endmodule
bind bsr_recovery bsr_recovery_chk chk (.*);
`default_nettype wire

// >>> dv/bsr_recovery_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h expected %h", $time, a, e); end end
// ==========================================
// bench
module bus_switch_recovery_frc_split_test;
  logic clk = '0, do_reset = '0, want_cold = '0, on_affected_pair = '0, on_failed_bus = '0;
  logic bus_switch = '0, cache_cfg_wr = '0, cache_enable_wr_data = '0, cache_enable_wr = '0;
  logic prefetch_enable_set = '0, prefetch_start = '0, prefetch_read_req = '0, data_req = '0;
  logic split_disable_wr_data = '0, split_disable_wr = '0, err_report = '0, err_transient = '0;
  logic interagent_request_hit = '0, bus_drive_req = '0, bus_error_report_req = '0;
  logic is_master = 1'b1, shadow_pair_joined = 1'b0, end_error_window = 1'b0;
  logic [1:0] switch_kind = '0;
  logic [2:0] cache_cfg_wr_data = '0;
  logic [7:0] err_confinement_identifier = '0, err_code = '0, register_a = 8'h22;
  // no scenario needs a software clear or a finished read
  wire prefetch_enable_clear = 1'b0, prefetch_read_done = 1'b0, reset_n, cold_reset;
  wire cache_invalidate_all, line_layout_eight, cache_enabled, prefetch_enable, prefetch_active;
  wire prefetch_outstanding, data_from_memory, own_permanent_error_bit, split_disable_bit;
  wire separated_pair, toggle_bit, active_component, silent, permanent_error, backplane_bus_oe;
  wire bus_error_report_lines_oe, interagent_request_ack;
  wire [2:0] cache_cfg;
  int failures = 0, checks_done = 0;
  always #10 clk = ~clk;
  bsr_recovery uut (.*);
  bsr_reset_src rsrc (.*);
  task tick;
    @(negedge clk);
  endtask
  task sw(input [1:0] k, input [2:0] e);
    switch_kind = k;
    bus_switch = 1;
    tick;
    bus_switch = 0;
    `CHK(cache_invalidate_all, on_affected_pair)
    `CHK(line_layout_eight, 1'b1)
    `CHK(cache_cfg, e)
    `CHK(prefetch_enable, 1'b0)
    tick;
  endtask
  task rst(input c);
    want_cold = c;
    do_reset = 1;
    tick;
    do_reset = 0;
    repeat (6) tick;
  endtask
  task cfg_wr(input [2:0] v);
    cache_cfg_wr_data = v;
    cache_cfg_wr = 1;
    tick;
    cache_cfg_wr = 0;
  endtask
  task err_hit;
    err_confinement_identifier = register_a;
    err_report = 1;
    tick;
    err_report = 0;
    `CHK(own_permanent_error_bit, !shadow_pair_joined)
  endtask
  task t_cache;
    cache_enable_wr_data = 1;
    cache_enable_wr = 1;
    prefetch_enable_set = 1;
    on_affected_pair = 1;
    cfg_wr(`BSR_CFG_FOUR4);
    cache_enable_wr = 0;
    prefetch_enable_set = 0;
    sw(`BSR_SW_FAIL, `BSR_CFG_TWO5);
    sw(`BSR_SW_ATTACH, `BSR_CFG_FOUR4);
    cfg_wr(`BSR_CFG_FOUR1);
    sw(`BSR_SW_DETACH, `BSR_CFG_TWO2);
    sw(`BSR_SW_ATTACH, `BSR_CFG_FOUR1);
    cfg_wr(`BSR_CFG_TWO5);
    sw(`BSR_SW_DETACH, `BSR_CFG_NONE3);
    `CHK(cache_enabled, 1'b1)
    sw(`BSR_SW_FAIL, `BSR_CFG_OFF);
    sw(`BSR_SW_ATTACH, `BSR_CFG_NONE3);
    sw(`BSR_SW_ATTACH, `BSR_CFG_TWO5);
    on_affected_pair = 0;
    sw(`BSR_SW_FAIL, `BSR_CFG_TWO5);
  endtask
  task t_prefetch;
    prefetch_start = 1;
    tick;
    prefetch_start = 0;
    `CHK(prefetch_active, 1'b0)
    prefetch_enable_set = 1;
    tick;
    prefetch_enable_set = 0;
    prefetch_start = 1;
    tick;
    prefetch_start = 0;
    prefetch_read_req = 1;
    tick;
    prefetch_read_req = 0;
    `CHK(prefetch_outstanding, 1'b1)
    on_affected_pair = 1;
    on_failed_bus = 1;
    sw(`BSR_SW_FAIL, `BSR_CFG_NONE3);
    `CHK(prefetch_outstanding, 1'b0)
    data_req = 1;
    tick;
    data_req = 0;
    `CHK(data_from_memory, 1'b1)
  endtask
  task t_err;
    err_transient = 1;
    err_code = 8'h5a;
    err_confinement_identifier = 8'h11;
    err_report = 1;
    tick;
    err_report = 0;
    end_error_window = 1;
    tick;
    end_error_window = 0;
    err_report = 1;
    tick;
    `CHK(permanent_error, 1'b0)
    tick;
    err_report = 0;
    err_transient = 0;
    `CHK(permanent_error, 1'b1)
  endtask
  task t_split;
    shadow_pair_joined = 1;
    err_hit;
    shadow_pair_joined = 0;
    err_hit;
    `CHK(separated_pair, 1'b0)
    rst(0);
    `CHK(separated_pair, 1'b1)
    `CHK({active_component, silent, toggle_bit}, 3'h4)
    err_hit;
    rst(0);
    `CHK({active_component, silent, toggle_bit}, 3'h2)
    bus_drive_req = 1;
    bus_error_report_req = 1;
    interagent_request_hit = 1;
    tick;
    `CHK({backplane_bus_oe, bus_error_report_lines_oe}, 2'h0)
    `CHK(interagent_request_ack, 1'b1)
    is_master = 0;
    rst(1);
    `CHK({separated_pair, split_disable_bit}, 2'h0)
    `CHK({backplane_bus_oe, bus_error_report_lines_oe}, 2'h3)
    err_hit;
    rst(0);
    `CHK({active_component, silent, toggle_bit}, 3'h2)
    rst(0);
    `CHK({active_component, silent, toggle_bit}, 3'h4)
    rst(1);
    split_disable_wr_data = 1;
    split_disable_wr = 1;
    tick;
    split_disable_wr = 0;
    `CHK(split_disable_bit, 1'b1)
    err_hit;
    rst(0);
    `CHK(separated_pair, 1'b0)
  endtask
  task close_out;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) tick;
    t_cache;
    t_prefetch;
    t_err;
    t_split;
    close_out;
  end
endmodule
`default_nettype wire
